// File: rtl/isp_pkg.sv
/*
 * Shared constants and types for the image sensor pixel port: the sensor
 * end and the capture controller end.
 * Assumes a 100 MHz controller clock and a sensor core clock that is four
 * times the master clock.
 */
package isp_pkg;
    localparam int ISP_PIX_W          = 12;
    localparam int ISP_CLK_PERIOD_NS  = 10;
    // Master clock made by the controller (12.5 MHz)
    localparam int ISP_MCLK_PERIOD_NS = 80;
    localparam int ISP_MCLK_MIN_KHZ   = 8000;
    localparam int ISP_MCLK_MAX_KHZ   = 16500;
    localparam int ISP_MCLK_HALF_CYC  =
        ISP_MCLK_PERIOD_NS / (2 * ISP_CLK_PERIOD_NS);
    // Serial bus bit period and snapshot request pulse
    localparam int ISP_SCL_PERIOD_NS  = 10000;
    localparam int ISP_SCL_QTR_CYC    =
        ISP_SCL_PERIOD_NS / (4 * ISP_CLK_PERIOD_NS);
    localparam int ISP_TRIG_PULSE_NS  = 200;
    localparam int ISP_TRIG_PULSE_CYC =
        (ISP_TRIG_PULSE_NS + ISP_CLK_PERIOD_NS - 1) / ISP_CLK_PERIOD_NS;
    // Serial address: upper five bits fixed, lower two from select pins
    localparam logic [6:0] ISP_SER_ADDR_BASE = 7'h48;
    localparam logic [3:0] ISP_BYTE_BITS     = 4'h8;
    localparam logic [4:0] ISP_SLOT_START    = 5'h00;
    localparam logic [4:0] ISP_SLOT_ACK_A    = 5'h09;
    localparam logic [4:0] ISP_SLOT_ACK_D    = 5'h12;
    localparam logic [4:0] ISP_SLOT_STOP     = 5'h13;
    // Control byte fields
    localparam int ISP_CTRL_PCLK_EN = 0;
    localparam int ISP_CTRL_SNAP    = 1;
    // Sensor pin sampling vector
    localparam int ISP_PIN_W   = 6;
    localparam int ISP_PIN_IDH = 5;
    localparam int ISP_PIN_IDL = 4;
    localparam int ISP_PIN_RST = 3;
    localparam int ISP_PIN_TRG = 2;
    localparam int ISP_PIN_SCL = 1;
    localparam int ISP_PIN_SDA = 0;
    localparam logic [ISP_PIN_W-1:0] ISP_PIN_IDLE = 6'h03;
    localparam logic [1:0] ISP_TEST_OFF = 2'h0;

    typedef enum logic [1:0] {
        ISP_F_WAIT   = 2'b00,
        ISP_F_EXPOSE = 2'b01,
        ISP_F_FRAME  = 2'b11
    } isp_frame_t;

    typedef enum logic [2:0] {
        ISP_S_IDLE = 3'b000,
        ISP_S_ADDR = 3'b001,
        ISP_S_AACK = 3'b011,
        ISP_S_DATA = 3'b010,
        ISP_S_DACK = 3'b110
    } isp_ser_t;
endpackage

// File: rtl/isp_link_if.sv
/*
 * Pin-level link between the sensor end and the capture controller end.
 * The serial data line is open drain with a pull-up, resolved here from
 * both enables; nothing else is resolved.
 */
`timescale 1ns/1ps
`default_nettype none
interface isp_link_if;
    import isp_pkg::*;
    logic                 master_clock_in;
    logic                 master_reset_n;
    logic                 snapshot_req;
    logic [1:0]           test_mode_in;
    logic                 bus_id_select_lo;
    logic                 bus_id_select_hi;
    logic                 serial_clk;
    logic                 host_sda_out;
    logic                 host_sda_oe_n;
    logic                 dev_sda_out;
    logic                 dev_sda_oe_n;
    logic                 serial_data_line;
    logic                 pixel_sample_clock_out;
    logic                 frame_valid;
    logic                 line_valid;
    logic [ISP_PIX_W-1:0] pixel_data;
    logic                 exposure_strobe;

    // Pulled high unless a party drives low
    assign serial_data_line = (dev_sda_oe_n | dev_sda_out)
                            & (host_sda_oe_n | host_sda_out);

    modport device (
        input  master_clock_in, master_reset_n, snapshot_req, test_mode_in,
        input  bus_id_select_lo, bus_id_select_hi, serial_clk,
        input  serial_data_line,
        output dev_sda_out, dev_sda_oe_n,
        output pixel_sample_clock_out, frame_valid, line_valid, pixel_data,
        output exposure_strobe
    );

    modport host (
        output master_clock_in, master_reset_n, snapshot_req, test_mode_in,
        output bus_id_select_lo, bus_id_select_hi, serial_clk,
        output host_sda_out, host_sda_oe_n,
        input  serial_data_line,
        input  pixel_sample_clock_out, frame_valid, line_valid, pixel_data,
        input  exposure_strobe
    );
endinterface
`default_nettype wire

// File: rtl/isp_sensor_end.sv
/*
 * Sensor end of the pixel port: frame timing, pixel bus, exposure strobe,
 * snapshot trigger handling and a write-only serial control byte.
 * Assumes clk is the on-chip PLL output, four times the master clock, so
 * the pixel clock made here by halving clk runs at twice the master clock.
 */
// Functional notes
// - Pixel word is 12 bits, bit 11 MSB
// - Receiver samples bus on falling pixel clock
// - Frame valid high in frame, low vblank
// - Line valid high only on active pixels
// - Snapshot request yields exactly one frame
// - Strobe high while whole array exposes
// - Active-low master reset holds device reset
// - Master clock supplied at 8 to 16.5 MHz
// - Test inputs tied low in normal use
// - Serial data open drain; serial clock input
// - Two select pins set serial bus address
// - One new pixel per pixel clock on line
// - Pixel clock runs at twice master clock
// - Pixel clock off after reset, then free-running
`timescale 1ns/1ps
`default_nettype none
module isp_sensor_end
    import isp_pkg::*;
#(
    parameter int ACT_COLS     = 1440,
    parameter int HBLANK       = 706,
    parameter int ACT_ROWS     = 1080,
    parameter int VBLANK       = 279,
    parameter int EXPOSE_TICKS = 1024
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    isp_link_if.device       link,
    output logic [7:0]       ctrl_q,
    output logic             frame_busy_q
);
    localparam int COL_TOT = ACT_COLS + HBLANK;
    localparam int ROW_TOT = ACT_ROWS + VBLANK;
    localparam int COL_W   = $clog2(COL_TOT);
    localparam int ROW_W   = $clog2(ROW_TOT);
    localparam int EXP_W   = $clog2(EXPOSE_TICKS + 1);
    localparam logic [COL_W-1:0] COL_LAST = COL_W'(COL_TOT - 1);
    localparam logic [COL_W-1:0] COL_LO   = COL_W'(HBLANK / 2);
    localparam logic [COL_W-1:0] COL_HI   = COL_W'(HBLANK / 2 + ACT_COLS);
    localparam logic [ROW_W-1:0] ROW_ACT  = ROW_W'(ACT_ROWS);
    localparam logic [ROW_W-1:0] ROW_LAST = ROW_W'(ROW_TOT - 1);
    localparam logic [EXP_W-1:0] EXP_LAST = EXP_W'(EXPOSE_TICKS - 1);

    if (ACT_COLS < 1 || ACT_ROWS < 1 || EXPOSE_TICKS < 1 || HBLANK < 2
        || VBLANK < 1) begin : g_bad_geometry
        $error("isp_sensor_end: frame geometry out of range");
    end

    // Pin sampling: three flops, change taken when stages 2 and 3 agree
    wire logic [ISP_PIN_W-1:0] pins_raw = {
        link.bus_id_select_hi, link.bus_id_select_lo, link.master_reset_n,
        link.snapshot_req, link.serial_clk, link.serial_data_line};
    logic [ISP_PIN_W-1:0] s1_q;
    logic [ISP_PIN_W-1:0] s2_q;
    logic [ISP_PIN_W-1:0] s3_q;
    logic [ISP_PIN_W-1:0] pin_q;
    logic [ISP_PIN_W-1:0] prev_q;
    wire logic [ISP_PIN_W-1:0] agree = ~(s2_q ^ s3_q);
    wire logic [ISP_PIN_W-1:0] pin_d = (s2_q & agree) | (pin_q & ~agree);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s1_q   <= ISP_PIN_IDLE;
            s2_q   <= ISP_PIN_IDLE;
            s3_q   <= ISP_PIN_IDLE;
            pin_q  <= ISP_PIN_IDLE;
            prev_q <= ISP_PIN_IDLE;
        end else begin
            s1_q   <= pins_raw;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            pin_q  <= pin_d;
            prev_q <= pin_q;
        end
    end

    wire logic rise_n = 1'b0;
    wire logic [ISP_PIN_W-1:0] rise = pin_q & ~prev_q;
    wire logic [ISP_PIN_W-1:0] fall = ~pin_q & prev_q;
    wire logic core_run = reset_n & pin_q[ISP_PIN_RST];

    // Serial control slave, write of one control byte
    wire logic scl_hi    = pin_q[ISP_PIN_SCL] & prev_q[ISP_PIN_SCL];
    wire logic start_det = scl_hi & fall[ISP_PIN_SDA];
    wire logic stop_det  = scl_hi & rise[ISP_PIN_SDA];
    wire logic [6:0] my_addr = {ISP_SER_ADDR_BASE[6:2],
        pin_q[ISP_PIN_IDH], pin_q[ISP_PIN_IDL]};
    isp_ser_t   ser_q;
    isp_ser_t   ser_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] sh_q;
    logic [7:0] sh_d;
    logic       oe_n_q;
    logic       oe_n_d;
    logic [7:0] ctrl_d;
    wire logic  shifting = (ser_q == ISP_S_ADDR) || (ser_q == ISP_S_DATA);
    wire logic  addr_hit = (sh_q == {my_addr, 1'b0});

    always_comb begin
        ser_d  = ser_q;
        cnt_d  = cnt_q;
        sh_d   = sh_q;
        oe_n_d = oe_n_q;
        ctrl_d = ctrl_q;
        if (rise[ISP_PIN_SCL] && shifting) begin
            sh_d  = {sh_q[6:0], pin_q[ISP_PIN_SDA]};
            cnt_d = cnt_q + 4'h1;
        end
        if (fall[ISP_PIN_SCL]) begin
            case (ser_q)
                ISP_S_ADDR: begin
                    if (cnt_q == ISP_BYTE_BITS) begin
                        cnt_d = 4'h0;
                        ser_d = addr_hit ? ISP_S_AACK : ISP_S_IDLE;
                        oe_n_d = ~addr_hit;
                    end
                end
                ISP_S_DATA: begin
                    if (cnt_q == ISP_BYTE_BITS) begin
                        cnt_d  = 4'h0;
                        ser_d  = ISP_S_DACK;
                        oe_n_d = 1'b0;
                        ctrl_d = sh_q;
                    end
                end
                ISP_S_AACK, ISP_S_DACK: begin
                    ser_d  = ISP_S_DATA;
                    oe_n_d = 1'b1;
                end
                default: ;
            endcase
        end
        if (start_det) begin
            ser_d  = ISP_S_ADDR;
            cnt_d  = 4'h0;
            oe_n_d = 1'b1;
        end else if (stop_det) begin
            ser_d  = ISP_S_IDLE;
            oe_n_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!core_run) begin
            ser_q  <= ISP_S_IDLE;
            cnt_q  <= 4'h0;
            sh_q   <= 8'h00;
            oe_n_q <= 1'b1;
            ctrl_q <= 8'h00;
        end else begin
            ser_q  <= ser_d;
            cnt_q  <= cnt_d;
            sh_q   <= sh_d;
            oe_n_q <= oe_n_d;
            ctrl_q <= ctrl_d;
        end
    end

    // Frame timing, advanced once per pixel clock period
    wire logic pclk_en = ctrl_q[ISP_CTRL_PCLK_EN];
    wire logic snap    = ctrl_q[ISP_CTRL_SNAP];
    logic                 pixel_sample_clock_out_q;
    isp_frame_t           frm_q;
    isp_frame_t           frm_d;
    logic [COL_W-1:0]     col_q;
    logic [ROW_W-1:0]     row_q;
    logic [EXP_W-1:0]     exp_q;
    logic                 pend_q;
    logic                 fv_q;
    logic                 lv_q;
    logic                 strobe_q;
    logic [ISP_PIX_W-1:0] data_q;
    wire logic tick     = pclk_en & ~pixel_sample_clock_out_q;
    wire logic col_end  = (col_q == COL_LAST);
    wire logic row_end  = col_end && (row_q == ROW_LAST);
    wire logic exp_end  = (exp_q == EXP_LAST);
    wire logic consume  = tick && (frm_q == ISP_F_WAIT) && pend_q;
    wire logic fv_d     = (frm_q == ISP_F_FRAME) && (row_q < ROW_ACT);
    wire logic lv_d     = fv_d && (col_q >= COL_LO) && (col_q < COL_HI);
    wire logic pend_d   = (rise[ISP_PIN_TRG] & snap)
                        | (pend_q & ~consume);

    always_comb begin
        frm_d = frm_q;
        case (frm_q)
            ISP_F_WAIT: begin
                if (!snap) begin
                    frm_d = ISP_F_FRAME;
                end else if (pend_q) begin
                    frm_d = ISP_F_EXPOSE;
                end
            end
            ISP_F_EXPOSE: frm_d = exp_end ? ISP_F_FRAME : ISP_F_EXPOSE;
            ISP_F_FRAME:  frm_d = (row_end && snap) ? ISP_F_WAIT : ISP_F_FRAME;
            default:      frm_d = ISP_F_WAIT;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!core_run) begin
            pixel_sample_clock_out_q <= 1'b0;
            frm_q    <= ISP_F_FRAME;
            col_q    <= '0;
            row_q    <= ROW_ACT;
            exp_q    <= '0;
            pend_q   <= 1'b0;
        end else begin
            pixel_sample_clock_out_q <= pclk_en & ~pixel_sample_clock_out_q;
            pend_q   <= pend_d;
            if (tick) begin
                frm_q <= frm_d;
                exp_q <= (frm_q == ISP_F_EXPOSE) ? exp_q + EXP_W'(1) : '0;
                if (frm_q != ISP_F_FRAME || col_end) begin
                    col_q <= '0;
                end else begin
                    col_q <= col_q + COL_W'(1);
                end
                if (frm_q != ISP_F_FRAME || row_end) begin
                    row_q <= '0;
                end else if (col_end) begin
                    row_q <= row_q + ROW_W'(1);
                end
            end
        end
    end

    // Outputs change with the rising pixel clock, mid-bit on the fall
    always_ff @(posedge clk) begin
        if (!core_run) begin
            fv_q         <= 1'b0;
            lv_q         <= 1'b0;
            strobe_q     <= 1'b0;
            data_q       <= '0;
            frame_busy_q <= 1'b0;
        end else begin
            frame_busy_q <= (frm_q != ISP_F_WAIT);
            if (tick) begin
                fv_q     <= fv_d;
                lv_q     <= lv_d;
                strobe_q <= (frm_q == ISP_F_EXPOSE);
                if (!fv_d) begin
                    data_q <= '0;
                end else if (lv_d) begin
                    data_q <= data_q + ISP_PIX_W'(1);
                end
            end
        end
    end

    assign link.pixel_sample_clock_out = pixel_sample_clock_out_q;
    assign link.frame_valid            = fv_q;
    assign link.line_valid             = lv_q;
    assign link.pixel_data             = data_q;
    assign link.exposure_strobe        = strobe_q;
    assign link.dev_sda_out            = rise_n;
    assign link.dev_sda_oe_n           = oe_n_q;
endmodule
`default_nettype wire

// File: rtl/isp_capture_end.sv
/*
 * Capture controller end of the pixel port: makes the master clock,
 * reset, trigger and serial bus, and captures pixels on the falling
 * pixel clock.
 * Assumes a 100 MHz clk and a pixel clock period of at least four clk
 * periods.
 */
`timescale 1ns/1ps
`default_nettype none
module isp_capture_end
    import isp_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    isp_link_if.host                  link,
    input  wire logic [1:0]           id_sel,
    input  wire logic                 snap_req,
    input  wire logic                 cmd_go,
    input  wire logic [7:0]           cmd_byte,
    output logic                      cmd_busy_q,
    output logic                      cmd_ack_q,
    output logic [ISP_PIX_W-1:0]      pix_word_q,
    output logic                      pix_valid_q,
    output logic                      frame_active_q
);
    localparam int MCLK_KHZ = 1000000 / ISP_MCLK_PERIOD_NS;
    if (MCLK_KHZ < ISP_MCLK_MIN_KHZ || MCLK_KHZ > ISP_MCLK_MAX_KHZ
        || ISP_MCLK_HALF_CYC < 1) begin : g_bad_mclk
        $error("isp_capture_end: master clock out of range");
    end
    localparam logic [7:0]  MCNT_LAST = 8'(ISP_MCLK_HALF_CYC - 1);
    localparam logic [15:0] QCNT_LAST = 16'(ISP_SCL_QTR_CYC - 1);
    localparam logic [7:0]  TRIG_LEN  = 8'(ISP_TRIG_PULSE_CYC);

    // Master clock, reset, test and select pins
    logic [7:0] mcnt_q;
    logic       mclk_q;
    logic       mrst_n_q;
    logic [1:0] test_q;
    logic [1:0] id_q;
    logic [7:0] trig_cnt_q;
    logic       trig_q;
    wire logic  mcnt_wrap = (mcnt_q == MCNT_LAST);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mcnt_q     <= 8'h00;
            mclk_q     <= 1'b0;
            mrst_n_q   <= 1'b0;
            test_q     <= ISP_TEST_OFF;
            id_q       <= 2'h0;
            trig_cnt_q <= 8'h00;
            trig_q     <= 1'b0;
        end else begin
            mcnt_q   <= mcnt_wrap ? 8'h00 : mcnt_q + 8'h01;
            mclk_q   <= mcnt_wrap ? ~mclk_q : mclk_q;
            mrst_n_q <= 1'b1;
            test_q   <= ISP_TEST_OFF;
            id_q     <= id_sel;
            if (snap_req) begin
                trig_cnt_q <= TRIG_LEN;
            end else if (trig_cnt_q != 8'h00) begin
                trig_cnt_q <= trig_cnt_q - 8'h01;
            end
            trig_q <= snap_req || (trig_cnt_q > 8'h01);
        end
    end

    // Serial master: start, address+write, ack, byte, ack, stop
    logic [2:0]  sda_s_q;
    logic        sda_f_q;
    logic [15:0] qcnt_q;
    logic [1:0]  qtr_q;
    logic [4:0]  slot_q;
    logic [17:0] tx_q;
    logic        scl_q;
    logic        sda_hi_q;
    logic        scl_d;
    logic        sda_hi_d;
    wire logic q_tick    = cmd_busy_q && (qcnt_q == QCNT_LAST);
    wire logic slot_end  = q_tick && (qtr_q == 2'h3);
    wire logic in_start  = (slot_q == ISP_SLOT_START);
    wire logic in_stop   = (slot_q == ISP_SLOT_STOP);
    wire logic ack_slot  = (slot_q == ISP_SLOT_ACK_A)
                         || (slot_q == ISP_SLOT_ACK_D);
    wire logic nack_seen = q_tick && (qtr_q == 2'h2) && ack_slot && sda_f_q;
    wire logic launch    = cmd_go && !cmd_busy_q;

    always_comb begin
        scl_d    = 1'b1;
        sda_hi_d = 1'b1;
        if (cmd_busy_q) begin
            if (in_start) begin
                sda_hi_d = (qtr_q < 2'h2);
            end else if (in_stop) begin
                scl_d    = (qtr_q != 2'h0);
                sda_hi_d = (qtr_q >= 2'h2);
            end else begin
                scl_d    = (qtr_q == 2'h1) || (qtr_q == 2'h2);
                sda_hi_d = tx_q[17];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sda_s_q    <= 3'h7;
            sda_f_q    <= 1'b1;
            qcnt_q     <= 16'h0000;
            qtr_q      <= 2'h0;
            slot_q     <= ISP_SLOT_START;
            tx_q       <= 18'h3ffff;
            cmd_busy_q <= 1'b0;
            cmd_ack_q  <= 1'b0;
            scl_q      <= 1'b1;
            sda_hi_q   <= 1'b1;
        end else begin
            sda_s_q <= {sda_s_q[1:0], link.serial_data_line};
            if (sda_s_q[1] == sda_s_q[2]) begin
                sda_f_q <= sda_s_q[2];
            end
            scl_q    <= scl_d;
            sda_hi_q <= sda_hi_d;
            if (launch) begin
                cmd_busy_q <= 1'b1;
                cmd_ack_q  <= 1'b1;
                qcnt_q     <= 16'h0000;
                qtr_q      <= 2'h0;
                slot_q     <= ISP_SLOT_START;
                tx_q <= {ISP_SER_ADDR_BASE[6:2], id_q, 1'b0, 1'b1,
                         cmd_byte, 1'b1};
            end else if (cmd_busy_q) begin
                qcnt_q <= q_tick ? 16'h0000 : qcnt_q + 16'h0001;
                if (q_tick) begin
                    qtr_q <= qtr_q + 2'h1;
                end
                if (nack_seen) begin
                    cmd_ack_q <= 1'b0;
                end
                if (slot_end) begin
                    slot_q <= slot_q + 5'h01;
                    if (!in_start) begin
                        tx_q <= {tx_q[16:0], 1'b1};
                    end
                    if (in_stop) begin
                        cmd_busy_q <= 1'b0;
                    end
                end
            end
        end
    end

    // Capture on the falling pixel clock; toggle marks each new word
    logic [ISP_PIX_W-1:0] cap_word_q;
    logic                 cap_tog_q;
    logic                 cap_fv_q;

    always_ff @(negedge link.pixel_sample_clock_out) begin
        cap_fv_q <= link.frame_valid;
        if (link.line_valid) begin
            cap_word_q <= link.pixel_data;
            cap_tog_q  <= ~cap_tog_q;
        end else if (!link.frame_valid && !cap_fv_q) begin
            cap_tog_q <= 1'b0;
        end
    end

    logic [1:0] tog_s_q;
    logic [1:0] fv_s_q;
    logic       tog_old_q;
    logic       fv_old_q;
    wire logic  new_word = (tog_s_q[1] != tog_old_q) && fv_s_q[1] && fv_old_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tog_s_q        <= 2'h0;
            fv_s_q         <= 2'h0;
            tog_old_q      <= 1'b0;
            fv_old_q       <= 1'b0;
            pix_word_q     <= '0;
            pix_valid_q    <= 1'b0;
            frame_active_q <= 1'b0;
        end else begin
            tog_s_q        <= {tog_s_q[0], cap_tog_q};
            fv_s_q         <= {fv_s_q[0], cap_fv_q};
            tog_old_q      <= tog_s_q[1];
            fv_old_q       <= fv_s_q[1];
            pix_valid_q    <= new_word;
            frame_active_q <= fv_s_q[1];
            if (new_word) begin
                pix_word_q <= cap_word_q;
            end
        end
    end

    assign link.master_clock_in  = mclk_q;
    assign link.master_reset_n   = mrst_n_q;
    assign link.test_mode_in     = test_q;
    assign link.bus_id_select_lo = id_q[0];
    assign link.bus_id_select_hi = id_q[1];
    assign link.snapshot_req     = trig_q;
    assign link.serial_clk       = scl_q;
    assign link.host_sda_out     = 1'b0;
    assign link.host_sda_oe_n    = sda_hi_q;
endmodule
`default_nettype wire

// File: tb/isp_link_sva.sv
/* Link checks in the sensor clock domain.
   Instantiated beside the link interface. */
`timescale 1ns/1ps
`default_nettype none
module isp_link_sva
    import isp_pkg::*;
#(
    parameter int ACT_COLS     = 8,
    parameter int EXPOSE_TICKS = 5
) (
    input wire logic                 clk,
    input wire logic                 reset_n,
    input wire logic                 pixel_sample_clock_out,
    input wire logic                 frame_valid,
    input wire logic                 line_valid,
    input wire logic [ISP_PIX_W-1:0] pixel_data,
    input wire logic                 exposure_strobe,
    input wire logic                 dev_sda_out,
    input wire logic                 dev_sda_oe_n
);
    logic [15:0] lv_n_q;
    logic [15:0] st_n_q;
    always_ff @(posedge clk) begin
        lv_n_q <= line_valid ? lv_n_q + 16'h1 : 16'h0;
        st_n_q <= exposure_strobe ? st_n_q + 16'h1 : 16'h0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_line_in_frame: assert property (
        line_valid |-> frame_valid) else $error("line outside frame");
    a_line_lead: assert property (
        $rose(frame_valid) |-> !line_valid [*3]) else $error("no lead");
    a_line_width: assert property (
        $fell(line_valid) |-> lv_n_q == 16'(2 * ACT_COLS))
        else $error("line width");
    a_pixel_step: assert property (
        $rose(pixel_sample_clock_out) && line_valid && $past(line_valid, 2)
        |-> pixel_data == $past(pixel_data, 2) + 12'h1)
        else $error("pixel step");
    a_edge_only: assert property (
        $changed(pixel_data) || $changed(frame_valid)
        |-> $rose(pixel_sample_clock_out)) else $error("off edge");
    a_pclk_free: assert property (
        $changed(pixel_sample_clock_out) |=> $changed(pixel_sample_clock_out))
        else $error("pixel clock stopped");
    a_strobe_len: assert property (
        $fell(exposure_strobe) |-> st_n_q == 16'(2 * EXPOSE_TICKS))
        else $error("strobe length");
    a_strobe_gap: assert property (
        exposure_strobe |-> !frame_valid) else $error("strobe in frame");
    a_frame_follow: assert property (
        $fell(exposure_strobe) |-> ##[0:4] frame_valid)
        else $error("no frame");
    a_sda_low: assert property (
        !dev_sda_oe_n |-> !dev_sda_out) else $error("sda driven high");
    // One serial bit slot is 500 sensor clocks
    a_sda_release: assert property (
        $fell(dev_sda_oe_n) |-> ##[490:510] $rose(dev_sda_oe_n))
        else $error("ack drive length");
    c_ack: cover property ($fell(dev_sda_oe_n));
    c_strobe: cover property ($fell(exposure_strobe));
    c_line: cover property ($fell(line_valid));
    c_frame: cover property ($fell(frame_valid));
endmodule
`default_nettype wire

// File: tb/image_sensor_pixel_port_tb_top.sv
/* Bench joining both link ends, random control bytes.
   Sensor clock is made here, four times the master clock. */
`timescale 1ns/1ps
`default_nettype none
module image_sensor_pixel_port_tb_top;
    localparam int AC = 8;
    localparam int AR = 3;
    logic clk = 0, clk_s = 0, reset_n = 0, snap_req = 0, cmd_go = 0;
    logic [1:0] id_sel = 2'h0;
    logic [7:0] cmd_byte = 8'h00, ctrl;
    logic [31:0] rnd = 32'h649a;
    logic [11:0] exp_w = 12'h1, pix_word_q;
    logic fa_q = 0, busy_s, cmd_busy_q, cmd_ack_q, pix_valid_q;
    logic frame_active_q;
    int errors = 0, samples_checked = 0, cyc = 0, frames = 0, cnt = 0, pk = 0;
    always #5 clk = ~clk;
    always @(posedge link.pixel_sample_clock_out) pk++;
    always begin
        if ($time == 0) #3;
        #10 clk_s = ~clk_s;
    end
    isp_link_if link ();
    isp_sensor_end #(.ACT_COLS(AC), .HBLANK(4), .ACT_ROWS(AR), .VBLANK(2),
        .EXPOSE_TICKS(5)) i_isp_sensor_end (.clk(clk_s), .reset_n(reset_n),
        .link(link), .ctrl_q(ctrl), .frame_busy_q(busy_s));
    isp_capture_end i_isp_capture_end (.clk(clk), .reset_n(reset_n),
        .link(link), .id_sel(id_sel), .snap_req(snap_req), .cmd_go(cmd_go),
        .cmd_byte(cmd_byte), .cmd_busy_q(cmd_busy_q), .cmd_ack_q(cmd_ack_q),
        .pix_word_q(pix_word_q), .pix_valid_q(pix_valid_q),
        .frame_active_q(frame_active_q));
    isp_link_sva #(.ACT_COLS(AC), .EXPOSE_TICKS(5)) i_isp_link_sva (
        .clk(clk_s), .reset_n(reset_n),
        .pixel_sample_clock_out(link.pixel_sample_clock_out),
        .frame_valid(link.frame_valid), .line_valid(link.line_valid),
        .pixel_data(link.pixel_data),
        .exposure_strobe(link.exposure_strobe),
        .dev_sda_out(link.dev_sda_out), .dev_sda_oe_n(link.dev_sda_oe_n));
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Second start while busy must be ignored
    task automatic send(input logic [7:0] b);
        int i;
        @(negedge clk);
        cmd_byte = b;
        cmd_go = 1;
        @(negedge clk);
        cmd_go = 0;
        repeat (300) @(negedge clk);
        cmd_byte = ~b;
        cmd_go = 1;
        @(negedge clk);
        cmd_go = 0;
        for (i = 0; i < 21000 && cmd_busy_q !== 1'b0; i++) @(negedge clk);
        check(cmd_ack_q, 16'h1);
        check(ctrl, b);
    endtask
    always @(posedge clk) begin
        fa_q <= frame_active_q;
        if (frame_active_q && !fa_q) begin
            exp_w = 12'h1;
            cnt = 0;
        end
        if (pix_valid_q) begin
            check(pix_word_q, exp_w);
            exp_w = exp_w + 12'h1;
            cnt++;
        end
        if (!frame_active_q && fa_q) begin
            frames++;
            check(16'(cnt), 16'(AC * AR));
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            errors++;
            wrap_up();
        end
    end
    initial begin
        int f, i, t;
        repeat (20) @(negedge clk);
        reset_n = 1;
        repeat (200) @(negedge clk);
        check(link.pixel_sample_clock_out, 16'h0);
        check(busy_s, 16'h1);
        check(link.test_mode_in, 16'h0);
        rnd = step(rnd);
        id_sel = rnd[1:0];
        send({rnd[9:4], 2'b01});
        f = frames;
        snap_req = 1;
        @(negedge clk);
        snap_req = 0;
        // One master clock period: its length and the pixel edges in it
        @(posedge link.master_clock_in) i = pk;
        t = cyc;
        @(posedge link.master_clock_in) t = cyc - t;
        check(16'(pk - i), 16'h2);
        check(16'(t > 6 && t < 13), 16'h1);
        for (i = 0; i < 5000 && frames < f + 3; i++) @(negedge clk);
        check(16'(frames - f), 16'h3);
        check(busy_s, 16'h1);
        $display("stream test done");
        rnd = step(rnd);
        id_sel = rnd[1:0];
        send({rnd[7:2], 2'b11});
        for (i = 0; i < 5000 && busy_s !== 1'b0; i++) @(negedge clk);
        repeat (20) @(negedge clk);
        f = frames;
        repeat (600) @(negedge clk);
        check(16'(frames - f), 16'h0);
        snap_req = 1;
        @(negedge clk);
        snap_req = 0;
        for (i = 0; i < 5000 && busy_s !== 1'b1; i++) @(negedge clk);
        for (i = 0; i < 5000 && busy_s !== 1'b0; i++) @(negedge clk);
        repeat (20) @(negedge clk);
        check(16'(frames - f), 16'h1);
        $display("snapshot test done");
        wrap_up();
    end
endmodule
`default_nettype wire
